// ### imu_pkg.sv
package imu_pkg;
  // Register byte addresses (even byte is low half)
  localparam logic [6:0] ADDR_ALARM = 7'h2e;
  localparam logic [6:0] ADDR_AUX = 7'h30;
  localparam logic [6:0] ADDR_GPIO = 7'h32;
  localparam logic [6:0] ADDR_MISC = 7'h34;
  localparam logic [6:0] ADDR_SMPL = 7'h36;
  localparam logic [6:0] ADDR_DIAG = 7'h3c;
  localparam logic [6:0] ADDR_GLOB = 7'h3e;
  // Values after reset
  localparam logic [15:0] GPIO_RST = 16'h0000;
  localparam logic [15:0] MISC_RST = 16'h0006;
  localparam logic [15:0] AUX_RST = 16'h0000;
  localparam logic [15:0] SMPL_RST = 16'h0001;
  localparam logic [15:0] ALARM_RST = 16'h0000;
  localparam logic [15:0] DIAG_RST = 16'h0000;
  // Writable bits of each register
  localparam logic [15:0] GPIO_WMASK = 16'h0f0f;
  localparam logic [15:0] MISC_WMASK = 16'h0fc7;
  localparam logic [15:0] AUX_WMASK = 16'h0fff;
  localparam logic [15:0] SMPL_WMASK = 16'h00ff;
  localparam logic [15:0] ALARM_WMASK = 16'hffd7;
  // Field positions
  localparam int GPIO_DIR_LSB = 0;
  localparam int GPIO_DATA_LSB = 8;
  localparam int LINE_FOUR = 3;
  localparam int OUT_SEL = 0;
  localparam int OUT_POL = 1;
  localparam int OUT_EN = 2;
  localparam int MISC_ORIGIN = 6;
  localparam int MISC_LINCOMP = 7;
  localparam int MISC_ST_POS = 8;
  localparam int MISC_ST_NEG = 9;
  localparam int MISC_ST_INT = 10;
  localparam int MISC_MEM_TEST = 11;
  localparam int GLOB_DAC_LATCH = 2;
  localparam int DIAG_MEM = 6;
  localparam int DIAG_ST_ANY = 5;
  localparam int DIAG_ST_LSB = 10;
  localparam int DAC_BITS = 12;
  // Converter scale, tenths of a microvolt per step
  localparam int DAC_STEP_UV_X10 = 8059;
  // Data-ready pulse timing
  localparam int CLK_NS = 100;
  localparam int DRDY_MIN_NS = 100000;
  localparam int DRDY_MAX_NS = 200000;
  localparam int DRDY_MIN_CYC = (DRDY_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int DRDY_MAX_CYC = DRDY_MAX_NS / CLK_NS;
  localparam int DRDY_CYC = (DRDY_MIN_CYC + DRDY_MAX_CYC) / 2;
  // Serial frame length
  localparam int FRAME_BITS = 16;
  // Test sequencer states
  typedef enum logic [1:0] {
    IMU_TS_IDLE = 2'b00,
    IMU_TS_SELF = 2'b01,
    IMU_TS_MEM = 2'b10
  } imu_test_state_t;
endpackage : imu_pkg

// ### imu_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
module imu_serial_port
  import imu_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  // Word side
  input wire logic [15:0] tx_word,
  output logic cmd_valid,
  output logic [15:0] cmd_word
);
  // Synchroniser stages: bit 2 sclk, bit 1 cs_n, bit 0 mosi
  logic [2:0] sy1, sy2;
  // Previous sclk and cs_n for edge detection
  logic [1:0] prev, next_prev;
  logic [15:0] rx_sh, next_rx_sh;
  logic [15:0] tx_sh, next_tx_sh;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic next_miso, next_miso_oe, next_cmd_valid;
  logic [15:0] next_cmd_word;
  logic rise, fall, frame_start;

  // Edges seen on second stage only
  always_comb begin
    next_prev = sy2[2:1];
    rise = sy2[2] && !prev[1] && !sy2[1];
    fall = !sy2[2] && prev[1] && !sy2[1];
    frame_start = !sy2[1] && prev[0];
    next_rx_sh = rx_sh;
    next_tx_sh = tx_sh;
    next_bit_cnt = bit_cnt;
    next_miso = miso;
    next_miso_oe = !sy2[1];
    next_cmd_valid = 1'b0;
    next_cmd_word = cmd_word;
    if (sy2[1]) begin
      // Deselected: abandon partial frame
      next_bit_cnt = '0;
    end else if (frame_start) begin
      // Load answer to previous read
      next_tx_sh = tx_word;
      next_bit_cnt = '0;
    end else if (fall) begin
      // Present next answer bit
      next_miso = tx_sh[15];
      next_tx_sh = {tx_sh[14:0], 1'b0};
    end else if (rise) begin
      // Sample command bit
      next_rx_sh = {rx_sh[14:0], sy2[0]};
      next_bit_cnt = bit_cnt + 5'h01;
      if (bit_cnt == 5'(FRAME_BITS - 1)) begin
        next_cmd_valid = 1'b1;
        next_cmd_word = {rx_sh[14:0], sy2[0]};
        next_bit_cnt = '0;
      end
    end
  end

  // Register stage
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sy1 <= 3'h6;
      sy2 <= 3'h6;
      prev <= 2'h3;
      rx_sh <= '0;
      tx_sh <= '0;
      bit_cnt <= '0;
      miso <= 1'b0;
      miso_oe <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_word <= '0;
    end else begin
      sy1 <= {sclk, cs_n, mosi};
      sy2 <= sy1;
      prev <= next_prev;
      rx_sh <= next_rx_sh;
      tx_sh <= next_tx_sh;
      bit_cnt <= next_bit_cnt;
      miso <= next_miso;
      miso_oe <= next_miso_oe;
      cmd_valid <= next_cmd_valid;
      cmd_word <= next_cmd_word;
    end
  end
endmodule : imu_serial_port
`default_nettype wire

// ### imu_io_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Line owner: misc, then alarm, then general
// - General low bits set line direction
// - Bits 11:8 drive outputs, read inputs
// - Line four clocks sampling when configured
// - Reset: data-ready active high on one
// - Misc bits enable, polarity, line select
// - Data-ready pulse 100 to 200 us
// - Memory test bit self-clears when done
// - Self-test bit posts flags, self-clears
// - Bits 9/8 hold negative/positive stimulus
// - Bits 7/6 enable compensation, alignment
// - Converter: 12-bit offset binary code
// - Latch copies whole converter word
// - General register resets to zero
// - Command bits self-clear after operation
// - Checksum result in status bit six
module imu_io_ctrl
  import imu_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  // General lines, bit 0 is line one
  input wire logic [3:0] gp_line_in,
  output logic [3:0] gp_line_out,
  output logic [3:0] gp_line_oe,
  // Sensor core events and alarm levels
  input wire logic data_ready_event,
  input wire logic [1:0] alarm_active,
  output logic ext_clk_mode,
  output logic ext_sample_strobe,
  output logic [7:0] sample_period_setting,
  // Automatic and memory tests
  output logic selftest_run,
  input wire logic selftest_done,
  input wire logic [5:0] selftest_fail,
  output logic mem_test_run,
  input wire logic mem_test_done,
  input wire logic mem_test_fail,
  // Sensor controls
  output logic stim_neg,
  output logic stim_pos,
  output logic lin_accel_comp,
  output logic origin_align,
  output logic [DAC_BITS-1:0] dac_code
);
  // Registers
  logic [15:0] general_line_control, next_general_line_control;
  logic [15:0] misc_control, next_misc_control;
  logic [15:0] aux_converter_value, next_aux_converter_value;
  logic [15:0] smpl_reg, next_smpl_reg;
  logic [15:0] alarm_control, next_alarm_control;
  logic [15:0] diag_status, next_diag_status;
  logic glob_latch, next_glob_latch;
  logic [DAC_BITS-1:0] next_dac_code;
  logic [15:0] rd_word, next_rd_word, rd_val;
  imu_test_state_t state, next_state;
  // Serial command decode
  logic cmd_valid;
  logic [15:0] cmd_word;
  logic wr_en, rd_en, hi;
  logic [6:0] addr;
  // Line drive and sampling
  logic [3:0] gp_s1, gp_s2, line_in_view;
  logic four_prev;
  logic [3:0] next_out, next_oe;
  logic next_ext_mode, next_strobe;
  logic drdy_act, next_drdy_act;
  logic [11:0] drdy_cnt, next_drdy_cnt;
  logic [11:0] drdy_len;
  logic drdy_lvl, alarm_lvl;

  // Same register, either byte
  function automatic logic hit(input logic [6:0] a, input logic [6:0] r);
    hit = (a[6:1] == r[6:1]);
  endfunction : hit

  // Line chosen by an enable and select bit
  function automatic logic line_hit(input logic en, input logic sel, input int idx);
    line_hit = en && (idx == (sel ? 1 : 0));
  endfunction : line_hit

  // Byte merge into one register
  function automatic logic [15:0] merge(input logic [15:0] old, input logic h,
                                        input logic [7:0] b, input logic [15:0] m);
    merge = (h ? {b, old[7:0]} : {old[15:8], b}) & m;
  endfunction : merge

  // Serial slave
  imu_serial_port u_port (
    .clk(clk),
    .resetn(resetn),
    .sclk(sclk),
    .cs_n(cs_n),
    .mosi(mosi),
    .miso(miso),
    .miso_oe(miso_oe),
    .tx_word(rd_word),
    .cmd_valid(cmd_valid),
    .cmd_word(cmd_word)
  );

  assign wr_en = cmd_valid && cmd_word[15];
  assign rd_en = cmd_valid && !cmd_word[15];
  assign addr = cmd_word[14:8];
  assign hi = addr[0];
  // Inputs read sampled level, outputs read stored level
  assign line_in_view = (general_line_control[11:8] & general_line_control[3:0]) |
    (gp_s2 & ~general_line_control[3:0]);

  // Read data selection
  always_comb begin
    rd_val = 16'h0000;
    if (hit(addr, ADDR_GPIO)) begin
      rd_val = {4'h0, line_in_view, 4'h0, general_line_control[3:0]};
    end else if (hit(addr, ADDR_MISC)) begin
      rd_val = misc_control;
    end else if (hit(addr, ADDR_AUX)) begin
      rd_val = aux_converter_value;
    end else if (hit(addr, ADDR_SMPL)) begin
      rd_val = smpl_reg;
    end else if (hit(addr, ADDR_ALARM)) begin
      rd_val = alarm_control;
    end else if (hit(addr, ADDR_DIAG)) begin
      rd_val = diag_status;
    end else if (hit(addr, ADDR_GLOB)) begin
      rd_val = {13'h0000, glob_latch, 2'h0};
    end
  end

  // Register file, test sequencer and converter latch
  always_comb begin
    next_general_line_control = general_line_control;
    next_misc_control = misc_control;
    next_aux_converter_value = aux_converter_value;
    next_smpl_reg = smpl_reg;
    next_alarm_control = alarm_control;
    next_diag_status = diag_status;
    next_glob_latch = 1'b0;
    next_dac_code = dac_code;
    next_rd_word = rd_word;
    next_state = state;
    // Status flags clear on read; results below win
    if (rd_en && hit(addr, ADDR_DIAG)) begin
      next_diag_status = DIAG_RST;
    end
    case (state)
      IMU_TS_IDLE: begin
        if (misc_control[MISC_ST_INT]) begin
          next_state = IMU_TS_SELF;
        end else if (misc_control[MISC_MEM_TEST]) begin
          next_state = IMU_TS_MEM;
        end
      end
      IMU_TS_SELF: begin
        if (selftest_done) begin
          next_misc_control[MISC_ST_INT] = 1'b0;
          next_diag_status[DIAG_ST_LSB +: 6] = selftest_fail;
          next_diag_status[DIAG_ST_ANY] = |selftest_fail;
          next_state = IMU_TS_IDLE;
        end
      end
      IMU_TS_MEM: begin
        if (mem_test_done) begin
          next_misc_control[MISC_MEM_TEST] = 1'b0;
          next_diag_status[DIAG_MEM] = mem_test_fail;
          next_state = IMU_TS_IDLE;
        end
      end
      default: begin
        next_state = IMU_TS_IDLE;
      end
    endcase
    // Whole word moves at once
    if (glob_latch) begin
      next_dac_code = aux_converter_value[DAC_BITS-1:0];
    end
    // Host write applied last so a new start wins
    if (wr_en) begin
      if (hit(addr, ADDR_GPIO)) begin
        next_general_line_control = merge(general_line_control, hi, cmd_word[7:0], GPIO_WMASK);
      end else if (hit(addr, ADDR_MISC)) begin
        next_misc_control = merge(next_misc_control, hi, cmd_word[7:0], MISC_WMASK);
      end else if (hit(addr, ADDR_AUX)) begin
        next_aux_converter_value = merge(aux_converter_value, hi, cmd_word[7:0], AUX_WMASK);
      end else if (hit(addr, ADDR_SMPL)) begin
        next_smpl_reg = merge(smpl_reg, hi, cmd_word[7:0], SMPL_WMASK);
      end else if (hit(addr, ADDR_ALARM)) begin
        next_alarm_control = merge(alarm_control, hi, cmd_word[7:0], ALARM_WMASK);
      end else if (hit(addr, ADDR_GLOB)) begin
        next_glob_latch = !hi && cmd_word[GLOB_DAC_LATCH];
      end
    end
    // Answer goes out in the next frame
    if (rd_en) begin
      next_rd_word = rd_val;
    end
  end

  // Register update
  always_ff @(posedge clk) begin
    if (!resetn) begin
      general_line_control <= GPIO_RST;
      misc_control <= MISC_RST;
      aux_converter_value <= AUX_RST;
      smpl_reg <= SMPL_RST;
      alarm_control <= ALARM_RST;
      diag_status <= DIAG_RST;
      glob_latch <= 1'b0;
      dac_code <= '0;
      rd_word <= '0;
      state <= IMU_TS_IDLE;
      selftest_run <= 1'b0;
      mem_test_run <= 1'b0;
      stim_neg <= 1'b0;
      stim_pos <= 1'b0;
      lin_accel_comp <= 1'b0;
      origin_align <= 1'b0;
      sample_period_setting <= SMPL_RST[7:0];
    end else begin
      general_line_control <= next_general_line_control;
      misc_control <= next_misc_control;
      aux_converter_value <= next_aux_converter_value;
      smpl_reg <= next_smpl_reg;
      alarm_control <= next_alarm_control;
      diag_status <= next_diag_status;
      glob_latch <= next_glob_latch;
      dac_code <= next_dac_code;
      rd_word <= next_rd_word;
      state <= next_state;
      selftest_run <= (next_state == IMU_TS_SELF);
      mem_test_run <= (next_state == IMU_TS_MEM);
      stim_neg <= next_misc_control[MISC_ST_NEG];
      stim_pos <= next_misc_control[MISC_ST_POS];
      lin_accel_comp <= next_misc_control[MISC_LINCOMP];
      origin_align <= next_misc_control[MISC_ORIGIN];
      sample_period_setting <= next_smpl_reg[7:0];
    end
  end

  // Pulse and line ownership
  always_comb begin
    next_drdy_act = drdy_act;
    next_drdy_cnt = drdy_cnt;
    if (drdy_act) begin
      if (drdy_cnt == 12'h000) begin
        next_drdy_act = 1'b0;
      end else begin
        next_drdy_cnt = drdy_cnt - 12'h001;
      end
    end else if (data_ready_event) begin
      next_drdy_act = 1'b1;
      next_drdy_cnt = 12'(DRDY_CYC - 1);
    end
    drdy_lvl = misc_control[OUT_POL] ? drdy_act : !drdy_act;
    alarm_lvl = alarm_control[OUT_POL] ? |alarm_active : !(|alarm_active);
    for (int i = 0; i < 4; i++) begin
      if (line_hit(misc_control[OUT_EN], misc_control[OUT_SEL], i)) begin
        next_oe[i] = 1'b1;
        next_out[i] = drdy_lvl;
      end else if (line_hit(alarm_control[OUT_EN], alarm_control[OUT_SEL], i)) begin
        next_oe[i] = 1'b1;
        next_out[i] = alarm_lvl;
      end else begin
        next_oe[i] = general_line_control[GPIO_DIR_LSB + i];
        next_out[i] = general_line_control[GPIO_DATA_LSB + i];
      end
    end
    next_ext_mode = !general_line_control[LINE_FOUR] && (smpl_reg[7:0] == 8'h00);
    next_strobe = ext_clk_mode && gp_s2[LINE_FOUR] && !four_prev;
  end

  // Line flops and input synchroniser
  always_ff @(posedge clk) begin
    if (!resetn) begin
      gp_s1 <= 4'h0;
      gp_s2 <= 4'h0;
      four_prev <= 1'b0;
      gp_line_out <= 4'h0;
      gp_line_oe <= 4'h0;
      ext_clk_mode <= 1'b0;
      ext_sample_strobe <= 1'b0;
      drdy_act <= 1'b0;
      drdy_cnt <= 12'h000;
      drdy_len <= 12'h000;
    end else begin
      gp_s1 <= gp_line_in;
      gp_s2 <= gp_s1;
      four_prev <= gp_s2[LINE_FOUR];
      gp_line_out <= next_out;
      gp_line_oe <= next_oe;
      ext_clk_mode <= next_ext_mode;
      ext_sample_strobe <= next_strobe;
      drdy_act <= next_drdy_act;
      drdy_cnt <= next_drdy_cnt;
      drdy_len <= drdy_act ? drdy_len + 12'h001 : 12'h000;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_drdy_width: assert property ($fell(drdy_act) |-> drdy_len == 12'(DRDY_CYC))
    else $error("data-ready pulse width wrong");
  a_line_prio: assert property (misc_control[OUT_EN] |=>
    gp_line_oe[$past(misc_control[OUT_SEL])] && gp_line_out[$past(misc_control[OUT_SEL])] ==
    ($past(misc_control[OUT_POL]) ? $past(drdy_act) : !$past(drdy_act)))
    else $error("data-ready line not driven");
  a_gpio_drive: assert property (!misc_control[OUT_EN] && !alarm_control[OUT_EN] |=>
    gp_line_oe == $past(general_line_control[3:0]) && gp_line_out == $past(general_line_control[11:8]))
    else $error("general line drive mismatch");
  a_ext_clock: assert property (##1 ext_clk_mode ==
    ($past(smpl_reg[7:0]) == 8'h00 && !$past(general_line_control[LINE_FOUR])))
    else $error("external clock mode mismatch");
  a_reset_vals: assert property ($rose(resetn) |-> misc_control == MISC_RST &&
    general_line_control == GPIO_RST)
    else $error("reset values wrong");
  a_mem_done: assert property (state == IMU_TS_MEM && mem_test_done && !wr_en |=>
    !misc_control[MISC_MEM_TEST] && diag_status[DIAG_MEM] == $past(mem_test_fail) && !mem_test_run)
    else $error("memory test completion wrong");
  a_self_done: assert property (state == IMU_TS_SELF && selftest_done && !wr_en |=>
    !misc_control[MISC_ST_INT] && diag_status[15:10] == $past(selftest_fail))
    else $error("self-test completion wrong");
  a_stim_hold: assert property (stim_neg == misc_control[MISC_ST_NEG] &&
    stim_pos == misc_control[MISC_ST_POS])
    else $error("stimulus not following control");
  a_dac_latch: assert property ($rose(glob_latch) |=>
    dac_code == $past(aux_converter_value[DAC_BITS-1:0]) && !glob_latch)
    else $error("converter latch failed");
  a_dac_hold: assert property (!$past(glob_latch) |-> $stable(dac_code))
    else $error("converter changed without latch");
endmodule : imu_io_ctrl
`default_nettype wire

// ### imu_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host side of the serial link, mode 3 framing
module imu_host_model
  import imu_pkg::*;
(
  // Clock
  input wire logic clk,
  // Serial pins
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  // Idle levels: clock high, select released
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b1;
  end

  // One 16-bit frame, MSB first; phases of 4 cycles beat the 2-flop sync
  task automatic frame(input logic [15:0] cmd, output logic [15:0] rsp);
    rsp = 16'h0000;
    @(posedge clk);
    #1;
    cs_n = 1'b0;
    for (int i = FRAME_BITS - 1; i >= 0; i--) begin
      @(posedge clk);
      #1;
      sclk = 1'b0;
      // Top bit selects write or read, then address and data byte
      mosi = cmd[i];
      repeat (4) @(posedge clk);
      #1;
      sclk = 1'b1;
      // A released answer line never passes for data
      rsp[i] = miso_oe ? miso : 1'bx;
      repeat (3) @(posedge clk);
    end
    @(posedge clk);
    #1;
    cs_n = 1'b1;
    // Unselected data line shows the inverse of the last bit
    mosi = ~mosi;
    repeat (8) @(posedge clk);
    // Step off the edge so the caller drives and samples settled values
    #1;
  endtask : frame
endmodule : imu_host_model
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import imu_pkg::*;
;
  // Design pins
  logic clk, resetn, sclk, cs_n, mosi, miso, miso_oe;
  logic [3:0] gp_line_in, gp_line_out, gp_line_oe, ext_pin;
  logic data_ready_event, selftest_done, mem_test_done, mem_test_fail;
  logic [1:0] alarm_active;
  logic [5:0] selftest_fail;
  logic ext_clk_mode, ext_sample_strobe, selftest_run, mem_test_run;
  logic stim_neg, stim_pos, lin_accel_comp, origin_align;
  logic [7:0] sample_period_setting;
  logic [DAC_BITS-1:0] dac_code;
  // Counters, seed and model state
  int error_cnt = 0;
  int n_checks = 0;
  int seed = 32'h2ca2;
  int w, k;
  logic [15:0] rd_val, g, exp_w;
  logic [3:0] e_oe;

  // Pin level resolved from every driver
  assign gp_line_in = (gp_line_oe & gp_line_out) | (~gp_line_oe & ext_pin);

  // Clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  imu_io_ctrl i_dut (.clk(clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe), .gp_line_in(gp_line_in), .gp_line_out(gp_line_out), .gp_line_oe(gp_line_oe),
    .data_ready_event(data_ready_event), .alarm_active(alarm_active), .ext_clk_mode(ext_clk_mode),
    .ext_sample_strobe(ext_sample_strobe), .sample_period_setting(sample_period_setting),
    .selftest_run(selftest_run), .selftest_done(selftest_done), .selftest_fail(selftest_fail),
    .mem_test_run(mem_test_run), .mem_test_done(mem_test_done), .mem_test_fail(mem_test_fail),
    .stim_neg(stim_neg), .stim_pos(stim_pos), .lin_accel_comp(lin_accel_comp),
    .origin_align(origin_align), .dac_code(dac_code));

  imu_host_model i_host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe));

  // Compare and count
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Wait n edges, then step off the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // Byte write, word write low then high, word read answered next frame
  task automatic wb(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] r;
    i_host.frame({1'b1, a, d}, r);
  endtask : wb
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    wb(a, d[7:0]);
    wb(a | 7'h01, d[15:8]);
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    logic [15:0] r;
    i_host.frame({1'b0, a, 8'h00}, r);
    i_host.frame(16'h0000, d);
  endtask : rd

  // Line enables and driven levels
  task automatic lines(input logic [3:0] oe, input logic [3:0] out);
    chk("line_oe", {12'h000, oe}, {12'h000, gp_line_oe});
    chk("line_out", {12'h000, out & oe}, {12'h000, gp_line_out & oe});
  endtask : lines

  // Data-ready pulse width on one line at its active level
  task automatic pulse(input int ln, input logic act, output int wd);
    int t;
    data_ready_event = 1'b1;
    cyc(1);
    data_ready_event = 1'b0;
    t = 0;
    wd = 0;
    while (gp_line_out[ln] !== act && t < 10) begin
      cyc(1);
      t++;
    end
    while (gp_line_out[ln] === act && wd < 3000) begin
      cyc(1);
      wd++;
    end
  endtask : pulse

  // Run a test routine with a done pulse and a fail result
  task automatic done_pulse(input logic mem, input logic [5:0] f);
    selftest_fail = f;
    mem_test_fail = f[0];
    if (mem) begin
      mem_test_done = 1'b1;
    end else begin
      selftest_done = 1'b1;
    end
    cyc(1);
    selftest_done = 1'b0;
    mem_test_done = 1'b0;
    cyc(2);
  endtask : done_pulse

  // Verdict and end of run
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  // Watchdog well beyond the expected length of the run
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    $display("MISMATCH watchdog expected end seen timeout");
    complete_run();
  end

  // Main sequence
  initial begin
    resetn = 1'b0;
    data_ready_event = 1'b0;
    alarm_active = 2'b00;
    selftest_done = 1'b0;
    selftest_fail = 6'h00;
    mem_test_done = 1'b0;
    mem_test_fail = 1'b0;
    ext_pin = 4'h0;
    repeat (3) @(posedge clk);
    #1;
    resetn = 1'b1;
    cyc(4);
    lines(4'b0001, 4'b0000);
    chk("dac_reset", 16'h0000, {4'h0, dac_code});
    rd(ADDR_GPIO, rd_val);
    chk("gpio_reset", GPIO_RST, rd_val);
    rd(ADDR_MISC, rd_val);
    chk("misc_reset", MISC_RST, rd_val);
    rd(ADDR_AUX, rd_val);
    chk("aux_reset", AUX_RST, rd_val);
    $display("Test reset values done");
    // Default pulse on line one, then active low on line two
    pulse(0, 1'b1, w);
    chk("drdy_width_ok", 16'h0001, {15'h0, w >= DRDY_MIN_CYC && w <= DRDY_MAX_CYC});
    wb(ADDR_MISC, 8'h05);
    pulse(1, 1'b0, w);
    chk("drdy_low_width_ok", 16'h0001, {15'h0, w >= DRDY_MIN_CYC && w <= DRDY_MAX_CYC});
    // Every enable, polarity and line choice at idle
    for (int v = 0; v < 8; v++) begin
      wb(ADDR_MISC, 8'(v));
      e_oe = v[2] ? (v[0] ? 4'b0010 : 4'b0001) : 4'b0000;
      lines(e_oe, (v[2] && !v[1]) ? e_oe : 4'b0000);
    end
    $display("Test data ready done");
    // Ownership: misc over alarm over general
    wb(ADDR_MISC, 8'h04);
    wr(ADDR_GPIO, 16'h0003);
    alarm_active = 2'b01;
    wr(ADDR_ALARM, 16'h0004);
    lines(4'b0011, 4'b0001);
    wb(ADDR_MISC, 8'h00);
    wr(ADDR_ALARM, 16'h0006);
    lines(4'b0011, 4'b0001);
    alarm_active = 2'b00;
    cyc(2);
    lines(4'b0011, 4'b0000);
    wr(ADDR_ALARM, 16'h0000);
    $display("Test priority done");
    // Random directions, levels and pin states
    for (int n = 0; n < 4; n++) begin
      g = 16'($random(seed)) & GPIO_WMASK;
      ext_pin = 4'($random(seed));
      wr(ADDR_GPIO, g);
      rd(ADDR_GPIO, rd_val);
      exp_w = {4'h0, (g[11:8] & g[3:0]) | (ext_pin & ~g[3:0]), 4'h0, g[3:0]};
      chk("gpio_read", exp_w, rd_val);
      lines(g[3:0], g[11:8]);
    end
    $display("Test general lines done");
    // External sample clock on line four
    ext_pin = 4'h0;
    wr(ADDR_GPIO, 16'h0000);
    wb(ADDR_SMPL, 8'h00);
    chk("ext_mode_on", 16'h0001, {15'h0, ext_clk_mode});
    ext_pin[3] = 1'b1;
    k = 0;
    while (ext_sample_strobe !== 1'b1 && k < 8) begin
      cyc(1);
      k++;
    end
    chk("ext_strobe", 16'h0001, {15'h0, ext_sample_strobe});
    wb(ADDR_SMPL, 8'h01);
    chk("ext_mode_off", 16'h0101, {7'h0, ~ext_clk_mode, sample_period_setting});
    $display("Test external clock done");
    // Converter: both bytes first, output moves only on latch
    wb(ADDR_AUX, 8'hd9);
    wb(ADDR_AUX | 7'h01, 8'h04);
    chk("dac_before_latch", 16'h0000, {4'h0, dac_code});
    wb(ADDR_GLOB, 8'h04);
    chk("dac_latched", 16'h04d9, {4'h0, dac_code});
    rd(ADDR_GLOB, rd_val);
    chk("glob_clear", 16'h0000, rd_val);
    wr(ADDR_AUX, 16'hf123);
    rd(ADDR_AUX, rd_val);
    chk("aux_upper_unused", 16'h0123, rd_val);
    wb(ADDR_GLOB, 8'h04);
    chk("dac_second", 16'h0123, {4'h0, dac_code});
    $display("Test converter done");
    // Manual stimulus and compensation levels, then upper byte cleared
    for (int p = 15; p >= 0; p -= 5) begin
      wr(ADDR_MISC, {6'h00, 4'(p), 6'h00});
      chk("misc_levels", 16'(p), {12'h0, stim_neg, stim_pos, lin_accel_comp, origin_align});
    end
    $display("Test manual controls done");
    // Automatic self-test with the sensor held still
    wb(ADDR_MISC | 7'h01, 8'h04);
    chk("selftest_run", 16'h0001, {15'h0, selftest_run});
    done_pulse(1'b0, 6'b100001);
    chk("selftest_stop", 16'h0000, {15'h0, selftest_run});
    rd(ADDR_MISC, rd_val);
    chk("misc_selfclear", 16'h0000, rd_val);
    rd(ADDR_DIAG, rd_val);
    chk("diag_selftest", 16'h8420, rd_val);
    // Memory test failing, then passing
    for (int f = 1; f >= 0; f--) begin
      wb(ADDR_MISC | 7'h01, 8'h08);
      chk("mem_run", 16'h0001, {15'h0, mem_test_run});
      done_pulse(1'b1, 6'(f));
      rd(ADDR_MISC, rd_val);
      chk("misc_mem_clear", 16'h0000, rd_val);
      rd(ADDR_DIAG, rd_val);
      chk("diag_mem", 16'(f) << DIAG_MEM, rd_val);
    end
    $display("Test diagnostics done");
    // Unmapped place: write ignored, read zero
    wb(7'h50, 8'h5a);
    rd(7'h50, rd_val);
    chk("unmapped", 16'h0000, rd_val);
    $display("Test unmapped done");
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
